// [rtl/ftc_pkg.sv]
// Package with the constants, types and helpers of the FIFO threshold configuration block.
package ftc_pkg;

    localparam logic [2:0] OFS_ALT_FUNC      = 3'h2;
    localparam logic [2:0] OFS_FLOW_LEVELS   = 3'h6;
    localparam logic [2:0] OFS_TRIG_LEVELS   = 3'h7;
    localparam logic [2:0] OFS_FIFO_READY    = 3'h7;
    localparam logic [2:0] ALT_FUNC_LCR_KEY  = 3'h4;

    localparam int         LO_NIBBLE_LSB     = 0;
    localparam int         HI_NIBBLE_LSB     = 4;
    localparam int         READY_TX_BIT      = 0;
    localparam int         READY_RX_BIT      = 4;
    localparam int         ALT_RSVD_BIT      = 0;
    localparam int         LEVEL_STEP_SHIFT  = 3;

    localparam logic [7:0] FLOW_LEVELS_RESET = 8'h00;
    localparam logic [7:0] TRIG_LEVELS_RESET = 8'h00;
    localparam logic [7:0] ALT_FUNC_RESET    = 8'h00;
    localparam logic [7:0] READ_IDLE_VALUE   = 8'h00;

    // Enhanced, modem and line control context owned by the surrounding UART.
    typedef struct packed {
        logic       enh_enable;
        logic       modem_wr_gate;
        logic       modem_rdy_enable;
        logic       loopback;
        logic [2:0] line_ctrl_top;
        logic       rts_flow_enable;
        logic [7:0] fifo_ctrl_tx_level;
        logic [7:0] fifo_ctrl_rx_level;
    } ftc_ctx_t;

    // Present occupancy of the two FIFOs.
    typedef struct packed {
        logic [7:0] tx_free;
        logic [7:0] rx_count;
        logic       rx_timeout;
    } ftc_fifo_state_t;

    typedef enum logic [2:0] {
        TGT_NONE,
        TGT_FLOW,
        TGT_TRIG,
        TGT_ALT,
        TGT_READY
    } ftc_target_t;

    // Converts a level nibble into a byte count in steps of eight.
    function automatic logic [7:0] ftc_nibble_to_bytes(input logic [3:0] nibble);
        ftc_nibble_to_bytes = {1'b0, nibble, 3'h0};
    endfunction

endpackage

// [rtl/ftc_sync.sv]
// Two flip-flop synchroniser for the register port pins.
`timescale 1ns/1ns
`default_nettype none
module ftc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             clock_in,
    input  wire logic             rst_in,
    // Pin side and synchronised side.
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] reset_value_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            stage1 <= '1;
            stage2 <= '1;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
        end
    end

    assign sync_out = stage2;
endmodule
`default_nettype wire

// [rtl/ftc_threshold_ctrl.sv]
// FIFO threshold configuration, ready status and flow control for the UART.
//
// Summary of operation
// - Low nibble of the flow levels register is the receive halt level.
// - High nibble of the flow levels register is the receive restore level.
// - Each flow level nibble counts bytes in steps of eight, 0 to 120.
// - Flow levels writes need enhanced enable and modem control bit six.
// - Low trigger nibble sets transmit trigger in free entries, 8 to 120.
// - High trigger nibble sets receive trigger in stored characters, 8 to 120.
// - Trigger levels writes need enhanced enable and modem control bit six.
// - A zero trigger nibble falls back to the FIFO control level.
// - Ready bit 0 shows enough transmit space; bits 3:1 and 7:5 read zero.
// - Ready bit 4 shows receive count above trigger or a receive timeout.
// - Ready status uses the fallback level when the nibble is zero.
// - Ready register is read-only at 111 with select, bit two, no loopback, and enhanced enable or bit six clear.
// - Alternate function register sits at 010 when line control top is 100.
// - Alternate function bit 0 is reserved and has no effect.
// - Request-to-send goes high at halt level and low at restore level.
// - Clear enhanced enable blocks writes to the gated control fields.
`timescale 1ns/1ns
`default_nettype none
module ftc_threshold_ctrl (
    // Clock and reset.
    input  wire logic                     clock_in,
    input  wire logic                     rst_in,
    // Parallel register port pins.
    input  wire logic                     cs_n_in,
    input  wire logic [2:0]               addr_in,
    input  wire logic                     wr_n_in,
    input  wire logic                     rd_n_in,
    input  wire logic [7:0]               data_in,
    output logic      [7:0]               data_out,
    output logic                          data_oe_out,
    // Context and FIFO state from the surrounding UART.
    input  wire ftc_pkg::ftc_ctx_t        ctx_in,
    input  wire ftc_pkg::ftc_fifo_state_t fifo_in,
    // Flow control and DMA status.
    output logic                          rts_out,
    output logic                          tx_ready_out,
    output logic                          rx_ready_out,
    // Levels handed to the rest of the UART.
    output logic      [7:0]               tx_trigger_out,
    output logic      [7:0]               rx_trigger_out,
    output logic      [7:0]               halt_level_out,
    output logic      [7:0]               restore_level_out,
    output logic      [7:0]               alt_func_out
);
    localparam int PIN_W = 14;

    wire logic [PIN_W-1:0] pins_raw;
    wire logic [PIN_W-1:0] pins_sync;
    wire logic [PIN_W-1:0] pins_idle;
    wire logic             cs_n_s;
    wire logic [2:0]       addr_s;
    wire logic             wr_n_s;
    wire logic             rd_n_s;
    wire logic [7:0]       data_s;

    logic                  wr_n_d;
    logic [7:0]            flow_levels;
    logic [7:0]            trig_levels;
    logic [7:0]            alt_func;
    logic [7:0]            fifo_ready;
    logic                  rts;
    logic [7:0]            read_data;
    logic                  read_drive;

    wire logic             selected;
    wire logic             level_gate;
    wire logic             hit_alt;
    wire logic             hit_flow;
    wire logic             hit_trig;
    wire logic             hit_ready;
    wire logic             write_edge;
    wire logic             read_active;
    ftc_pkg::ftc_target_t  target;
    wire logic [7:0]       tx_level;
    wire logic [7:0]       rx_level;
    wire logic [7:0]       halt_bytes;
    wire logic [7:0]       restore_bytes;
    wire logic             tx_space_ok;
    wire logic             rx_data_ok;
    logic      [7:0]       next_fifo_ready;
    wire logic             next_rts;
    logic      [7:0]       next_read_data;

    // Pin synchronisation; idle pins rest high.
    assign pins_raw  = {cs_n_in, addr_in, wr_n_in, rd_n_in, data_in};
    assign pins_idle = '1;

    ftc_sync #(
        .WIDTH          (PIN_W)
    ) u_pin_sync (
        .clock_in       (clock_in),
        .rst_in         (rst_in),
        .async_in       (pins_raw),
        .reset_value_in (pins_idle),
        .sync_out       (pins_sync)
    );

    assign cs_n_s = pins_sync[13];
    assign addr_s = pins_sync[12:10];
    assign wr_n_s = pins_sync[9];
    assign rd_n_s = pins_sync[8];
    assign data_s = pins_sync[7:0];

    // Address decode.
    assign selected   = ~cs_n_s;
    assign level_gate = ctx_in.enh_enable & ctx_in.modem_wr_gate;
    assign hit_alt    = selected & (addr_s == ftc_pkg::OFS_ALT_FUNC)
                      & (ctx_in.line_ctrl_top == ftc_pkg::ALT_FUNC_LCR_KEY);
    assign hit_flow   = selected & (addr_s == ftc_pkg::OFS_FLOW_LEVELS) & level_gate;
    assign hit_trig   = selected & (addr_s == ftc_pkg::OFS_TRIG_LEVELS) & level_gate;
    assign hit_ready  = selected & (addr_s == ftc_pkg::OFS_FIFO_READY) & ~level_gate
                      & ctx_in.modem_rdy_enable & ~ctx_in.loopback;

    always_comb begin
        if (hit_alt) begin
            target = ftc_pkg::TGT_ALT;
        end else if (hit_flow) begin
            target = ftc_pkg::TGT_FLOW;
        end else if (hit_trig) begin
            target = ftc_pkg::TGT_TRIG;
        end else if (hit_ready) begin
            target = ftc_pkg::TGT_READY;
        end else begin
            target = ftc_pkg::TGT_NONE;
        end
    end

    // A write is taken when the synchronised write strobe returns high.
    assign write_edge  = wr_n_s & ~wr_n_d & selected;
    assign read_active = ~rd_n_s & (target != ftc_pkg::TGT_NONE);

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wr_n_d <= 1'b1;
        end else begin
            wr_n_d <= wr_n_s;
        end
    end

    // Register writes; the ready register ignores writes.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            flow_levels <= ftc_pkg::FLOW_LEVELS_RESET;
            trig_levels <= ftc_pkg::TRIG_LEVELS_RESET;
            alt_func    <= ftc_pkg::ALT_FUNC_RESET;
        end else if (write_edge) begin
            unique case (target)
                ftc_pkg::TGT_FLOW: begin
                    flow_levels <= data_s;
                end
                ftc_pkg::TGT_TRIG: begin
                    trig_levels <= data_s;
                end
                ftc_pkg::TGT_ALT: begin
                    alt_func    <= data_s;
                end
                ftc_pkg::TGT_READY, ftc_pkg::TGT_NONE: begin
                    flow_levels <= flow_levels;
                end
            endcase
        end
    end

    // Active trigger levels.
    ftc_trigger_sel u_tx_trigger (
        .nibble_in          (trig_levels[ftc_pkg::LO_NIBBLE_LSB +: 4]),
        .fifo_ctrl_level_in (ctx_in.fifo_ctrl_tx_level),
        .level_out          (tx_level)
    );

    ftc_trigger_sel u_rx_trigger (
        .nibble_in          (trig_levels[ftc_pkg::HI_NIBBLE_LSB +: 4]),
        .fifo_ctrl_level_in (ctx_in.fifo_ctrl_rx_level),
        .level_out          (rx_level)
    );

    // Flow control levels in bytes.
    assign halt_bytes    = ftc_pkg::ftc_nibble_to_bytes(flow_levels[ftc_pkg::LO_NIBBLE_LSB +: 4]);
    assign restore_bytes = ftc_pkg::ftc_nibble_to_bytes(flow_levels[ftc_pkg::HI_NIBBLE_LSB +: 4]);

    // Ready status from present occupancy.
    assign tx_space_ok = (fifo_in.tx_free >= tx_level);
    assign rx_data_ok  = (fifo_in.rx_count > rx_level) | fifo_in.rx_timeout;

    always_comb begin
        next_fifo_ready                       = 8'h00;
        next_fifo_ready[ftc_pkg::READY_TX_BIT] = tx_space_ok;
        next_fifo_ready[ftc_pkg::READY_RX_BIT] = rx_data_ok;
    end

    // Request-to-send flow control with hysteresis; halt above restore is the host's duty.
    assign next_rts = ~ctx_in.rts_flow_enable ? 1'b0 :
                      (fifo_in.rx_count >= halt_bytes) ? 1'b1 :
                      (fifo_in.rx_count <= restore_bytes) ? 1'b0 : rts;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            fifo_ready <= 8'h00;
            rts        <= 1'b0;
        end else begin
            fifo_ready <= next_fifo_ready;
            rts        <= next_rts;
        end
    end

    // Read data selection; the reserved alternate bit reads zero.
    always_comb begin
        next_read_data = ftc_pkg::READ_IDLE_VALUE;
        unique case (target)
            ftc_pkg::TGT_FLOW: begin
                next_read_data = flow_levels;
            end
            ftc_pkg::TGT_TRIG: begin
                next_read_data = trig_levels;
            end
            ftc_pkg::TGT_ALT: begin
                next_read_data                       = alt_func;
                next_read_data[ftc_pkg::ALT_RSVD_BIT] = 1'b0;
            end
            ftc_pkg::TGT_READY: begin
                next_read_data = fifo_ready;
            end
            ftc_pkg::TGT_NONE: begin
                next_read_data = ftc_pkg::READ_IDLE_VALUE;
            end
        endcase
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            read_data  <= ftc_pkg::READ_IDLE_VALUE;
            read_drive <= 1'b0;
        end else begin
            read_data  <= next_read_data;
            read_drive <= read_active;
        end
    end

    // Outputs.
    assign data_out          = read_data;
    assign data_oe_out       = read_drive;
    assign rts_out           = rts;
    assign tx_ready_out      = fifo_ready[ftc_pkg::READY_TX_BIT];
    assign rx_ready_out      = fifo_ready[ftc_pkg::READY_RX_BIT];
    assign tx_trigger_out    = tx_level;
    assign rx_trigger_out    = rx_level;
    assign halt_level_out    = halt_bytes;
    assign restore_level_out = restore_bytes;
    assign alt_func_out      = {alt_func[7:1], 1'b0};
endmodule
`default_nettype wire

// [rtl/ftc_trigger_sel.sv]
// Selection of the active trigger level for one FIFO direction.
`timescale 1ns/1ns
`default_nettype none
module ftc_trigger_sel (
    // Programmed nibble and fallback level.
    input  wire logic [3:0] nibble_in,
    input  wire logic [7:0] fifo_ctrl_level_in,
    // Active level in bytes.
    output logic      [7:0] level_out
);
    wire logic       use_fallback;
    wire logic [7:0] nibble_bytes;

    assign use_fallback = (nibble_in == 4'h0);
    assign nibble_bytes = ftc_pkg::ftc_nibble_to_bytes(nibble_in);
    assign level_out    = use_fallback ? fifo_ctrl_level_in : nibble_bytes;
endmodule
`default_nettype wire

// [testbench/ftc_host_model.sv]
// Host processor model that drives the parallel register port.
`timescale 1ns/1ns
`default_nettype none
module ftc_host_model (
    // Clock.
    input  wire logic       clock_in,
    // Register port pins.
    output logic            cs_n_out,
    output logic            wr_n_out,
    output logic            rd_n_out,
    output logic [2:0]      addr_out,
    output logic [7:0]      data_out
);
    initial begin
        cs_n_out = 1'b1;
        wr_n_out = 1'b1;
        rd_n_out = 1'b1;
        addr_out = 3'h0;
        data_out = 8'h00;
    end
    // Released lines show inverted values so nothing stale looks valid.
    task automatic release_bus();
        cs_n_out = 1'b1;
        addr_out = ~addr_out;
        data_out = ~data_out;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clock_in);
        cs_n_out = 1'b0;
        addr_out = a;
        data_out = d;
        wr_n_out = 1'b0;
        repeat (4) @(negedge clock_in);
        wr_n_out = 1'b1;
        repeat (4) @(negedge clock_in);
        release_bus();
    endtask
    task automatic rd(input logic [2:0] a);
        @(negedge clock_in);
        cs_n_out = 1'b0;
        addr_out = a;
        rd_n_out = 1'b0;
        repeat (5) @(negedge clock_in);
        rd_n_out = 1'b1;
        release_bus();
        repeat (4) @(negedge clock_in);
    endtask
endmodule
`default_nettype wire

// [testbench/ftc_monitor.sv]
// Port checker for the FIFO threshold block and its bind.
`timescale 1ns/1ns
`default_nettype none
module ftc_monitor (
    // Clock, reset and bus pins.
    input wire logic                     clock_in,
    input wire logic                     rst_in,
    input wire logic                     cs_n_in,
    input wire logic [2:0]               addr_in,
    input wire logic                     rd_n_in,
    input wire ftc_pkg::ftc_ctx_t        ctx_in,
    input wire ftc_pkg::ftc_fifo_state_t fifo_in,
    // Outputs under watch.
    input wire logic                     data_oe_out,
    input wire logic                     rts_out,
    input wire logic                     tx_ready_out,
    input wire logic                     rx_ready_out,
    input wire logic [7:0]               tx_trigger_out,
    input wire logic [7:0]               rx_trigger_out,
    input wire logic [7:0]               halt_level_out,
    input wire logic [7:0]               restore_level_out,
    input wire logic [7:0]               alt_func_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    chk_tx_ready_set: assert property (fifo_in.tx_free >= tx_trigger_out |=> tx_ready_out)
        else $error("tx ready low with space");
    chk_tx_ready_clr: assert property (fifo_in.tx_free < tx_trigger_out |=> !tx_ready_out)
        else $error("tx ready high without space");
    chk_rx_ready_set: assert property (fifo_in.rx_count > rx_trigger_out || fifo_in.rx_timeout |=> rx_ready_out)
        else $error("rx ready low");
    chk_rx_ready_clr: assert property (!(fifo_in.rx_count > rx_trigger_out || fifo_in.rx_timeout) |=> !rx_ready_out)
        else $error("rx ready high");
    chk_tx_trig_range: assert property (tx_trigger_out != ctx_in.fifo_ctrl_tx_level |->
        tx_trigger_out[2:0] == 3'h0 && tx_trigger_out inside {[8'h08:8'h78]})
        else $error("tx trigger off grid");
    chk_flow_step: assert property (halt_level_out[2:0] == 3'h0 && halt_level_out <= 8'h78)
        else $error("halt level off grid");
    chk_rts_halt: assert property (ctx_in.rts_flow_enable && fifo_in.rx_count >= halt_level_out |=> rts_out)
        else $error("rts not raised");
    chk_rts_restore: assert property (ctx_in.rts_flow_enable && fifo_in.rx_count <= restore_level_out
        && fifo_in.rx_count < halt_level_out |=> !rts_out) else $error("rts not dropped");
    chk_alt_rsvd: assert property (alt_func_out[0] == 1'b0)
        else $error("alt bit zero set");
    chk_alt_read: assert property ($fell(rd_n_in) && !cs_n_in && addr_in == ftc_pkg::OFS_ALT_FUNC
        && ctx_in.line_ctrl_top == ftc_pkg::ALT_FUNC_LCR_KEY |-> ##3 data_oe_out) else $error("alt read lost");
    cover property ($rose(rts_out));
    cover property ($rose(data_oe_out));
    cover property (fifo_in.rx_timeout && rx_ready_out);
endmodule
bind ftc_threshold_ctrl ftc_monitor mon (.clock_in, .rst_in, .cs_n_in, .addr_in, .rd_n_in, .ctx_in,
    .fifo_in, .data_oe_out, .rts_out, .tx_ready_out, .rx_ready_out, .tx_trigger_out, .rx_trigger_out,
    .halt_level_out, .restore_level_out, .alt_func_out);
`default_nettype wire

// [testbench/tb.sv]
// Self-checking testbench of the FIFO threshold block.
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin failures++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module tb;
    logic                     clock_in;
    logic                     rst_in;
    logic                     cs_n, wr_n, rd_n, data_oe, rts, txr, rxr, oe_q, exp_rts;
    logic [2:0]               addr;
    logic [7:0]               wdata, rdata, tx_trig, rx_trig, halt, restore, alt, exp_v;
    logic [31:0]              seed;
    ftc_pkg::ftc_ctx_t        ctx;
    ftc_pkg::ftc_fifo_state_t fifo;
    logic [7:0]               exp_q[$];
    int                       failures, total_checks, n_res, k;
    ftc_host_model host (.clock_in(clock_in), .cs_n_out(cs_n), .wr_n_out(wr_n), .rd_n_out(rd_n),
        .addr_out(addr), .data_out(wdata));
    ftc_threshold_ctrl dut (.clock_in(clock_in), .rst_in(rst_in), .cs_n_in(cs_n), .addr_in(addr),
        .wr_n_in(wr_n), .rd_n_in(rd_n), .data_in(wdata), .data_out(rdata), .data_oe_out(data_oe),
        .ctx_in(ctx), .fifo_in(fifo), .rts_out(rts), .tx_ready_out(txr), .rx_ready_out(rxr),
        .tx_trigger_out(tx_trig), .rx_trigger_out(rx_trig), .halt_level_out(halt),
        .restore_level_out(restore), .alt_func_out(alt));
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction
    task automatic finish_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic rd_exp(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    initial begin
        #100000;
        failures++;
        finish_test();
    end
    // Each new read answer is matched against the oldest expectation.
    always @(negedge clock_in) begin
        if (data_oe && !oe_q) begin
            n_res++;
            if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
            else begin
                exp_v = exp_q.pop_front();
                `CHK(rdata, exp_v)
            end
        end
        oe_q = data_oe;
    end
    initial begin
        oe_q = 1'b0;
        seed = 32'h5FD3;
        rst_in = 1'b1;
        ctx = '{1'b1, 1'b1, 1'b1, 1'b0, 3'h4, 1'b0, 8'h10, 8'h18};
        fifo = '{8'h00, 8'h00, 1'b0};
        repeat (4) @(negedge clock_in);
        rst_in = 1'b0;
        repeat (3) @(negedge clock_in);
        `CHK(tx_trig, 8'h10)
        `CHK(rx_trig, 8'h18)
        host.wr(3'h7, 8'h53);
        `CHK(tx_trig, 8'h18)
        `CHK(rx_trig, 8'h28)
        ctx.modem_wr_gate = 1'b0;
        host.wr(3'h7, 8'hFF);
        host.wr(3'h6, 8'hFF);
        `CHK(tx_trig, 8'h18)
        `CHK(halt, 8'h00)
        ctx.modem_wr_gate = 1'b1;
        for (int n = 0; n < 16; n++) begin
            host.wr(3'h6, {4'(15 - n), 4'(n)});
            `CHK(halt, 8'(n * 8))
            `CHK(restore, 8'((15 - n) * 8))
        end
        host.wr(3'h6, 8'h4C);
        rd_exp(3'h6, 8'h4C);
        host.wr(3'h2, 8'hA5);
        `CHK(alt, 8'hA4)
        rd_exp(3'h2, 8'hA4);
        ctx.line_ctrl_top = 3'h3;
        k = n_res;
        host.rd(3'h2);
        host.rd(3'h3);
        `CHK(n_res, k)
        ctx.line_ctrl_top = 3'h4;
        ctx.enh_enable = 1'b0;
        fifo = '{8'h1E, 8'h0A, 1'b0};
        rd_exp(3'h7, 8'h01);
        fifo.rx_timeout = 1'b1;
        rd_exp(3'h7, 8'h11);
        ctx.loopback = 1'b1;
        k = n_res;
        host.rd(3'h7);
        `CHK(n_res, k)
        ctx.loopback = 1'b0;
        ctx.enh_enable = 1'b1;
        ctx.rts_flow_enable = 1'b1;
        exp_rts = 1'b0;
        for (int i = 0; i < 80; i++) begin
            seed = xs(seed);
            fifo = '{{1'b0, seed[6:0]}, {1'b0, seed[14:8]}, seed[15] & seed[16]};
            if (fifo.rx_count >= 8'h60) exp_rts = 1'b1;
            else if (fifo.rx_count <= 8'h20) exp_rts = 1'b0;
            repeat (2) @(negedge clock_in);
            `CHK(txr, fifo.tx_free >= 8'h18)
            `CHK(rxr, fifo.rx_count > 8'h28 || fifo.rx_timeout)
            `CHK(rts, exp_rts)
        end
        `CHK(exp_q.size(), 0)
        finish_test();
    end
endmodule
`default_nettype wire
